// ### design/tsc_defines.svh
`ifndef TSC_DEFINES_SVH
`define TSC_DEFINES_SVH
// opcodes and instruction formats
`define TSC_OP_RPLACD     6'h23
`define TSC_OP_ARRAY      6'h24
`define TSC_FMT_RR        3'h6
`define TSC_FMT_RIS       3'h7
`define TSC_FMT_RIL       3'h5
// tagged word layout: cdr code, tag, data
`define TSC_TAG_HI        37
`define TSC_TAG_LO        32
`define TSC_DATA_HI       31
`define TSC_CDR_NORMAL    2'h0
// tag codes, values arbitrary but distinct
`define TSC_TAG_FIXNUM    6'h08
`define TSC_TAG_CHAR      6'h1A
`define TSC_TAG_LOCATIVE  6'h09
`define TSC_TAG_HDR_P     6'h3C
`define TSC_TAG_HDR_I     6'h3D
`define TSC_TAG_GC_FWD    6'h3E
`define TSC_TAG_MON_FWD   6'h01
`define TSC_TAG_EVCP      6'h04
`define TSC_TAG_ONEQ_FWD  6'h02
`define TSC_TAG_HDR_FWD   6'h03
`define TSC_TAG_ELEM_FWD  6'h05
`define TSC_TAG_BOUND     6'h06
`define TSC_TAG_LOGIC     6'h07
// array descriptor word fields
`define TSC_AHR_ET_HI     31
`define TSC_AHR_ET_LO     30
`define TSC_AHR_PK_HI     29
`define TSC_AHR_PK_LO     27
`define TSC_AHR_LONG      23
`define TSC_AHR_INHIBIT   12
`define TSC_ET_FIXNUM     2'h0
`define TSC_ET_CHAR       2'h1
`define TSC_ET_BOOL       2'h2
`define TSC_CHAR_OVER_BIT 20
// register offsets and bus answers
`define TSC_REG_LIST_CODE 8'h00
`define TSC_REG_ARR_DESC  8'h04
`define TSC_REG_ARR_LEN   8'h08
`define TSC_REG_MEM_OFS   8'h0C
`define TSC_REG_PACK_SH   8'h10
`define TSC_REG_STATUS    8'h14
`define TSC_RESP_OKAY     2'h0
`define TSC_RESP_SLVERR   2'h2
`endif

// ### design/tsc_pkg.sv
package tsc_pkg;
  typedef enum logic [3:0] {
    TSC_ST_IDLE = 4'h1,
    TSC_ST_RD   = 4'h2,
    TSC_ST_WR   = 4'h4,
    TSC_ST_DONE = 4'h8
  } tsc_state_e;
  typedef enum logic [3:0] {
    TSC_TRAP_NONE      = 4'h0,
    TSC_TRAP_SRC_TYPE  = 4'h1,
    TSC_TRAP_LIST_CODE = 4'h2,
    TSC_TRAP_ELEMENT   = 4'h3,
    TSC_TRAP_LONG_PFX  = 4'h4,
    TSC_TRAP_RANGE     = 4'h5,
    TSC_TRAP_PACKED    = 4'h6,
    TSC_TRAP_MEM_ERROR = 4'h7,
    TSC_TRAP_MONITOR   = 4'h8,
    TSC_TRAP_INDIRECT  = 4'h9,
    TSC_TRAP_BOUND     = 4'hA,
    TSC_TRAP_LOGIC_VAR = 4'hB,
    TSC_TRAP_TRANSPORT = 4'hC
  } tsc_trap_e;
  typedef struct packed {
    logic [5:0]  opcode;
    logic [2:0]  fmt;
    logic [5:0]  typ;
    logic [39:0] src1;
    logic [39:0] src2;
    logic [11:0] imm12;
    logic [37:0] imm38;
  } tsc_req_s;
  typedef struct packed {
    logic        req;
    logic        we;
    logic [31:0] addr;
    logic [39:0] wdata;
  } tsc_mem_s;
endpackage

// ### design/tsc_store_check.sv
`timescale 1ns/1ps
`default_nettype none
`include "tsc_defines.svh"
module tsc_store_check (
  input  wire logic              clock_i,
  input  wire logic              rst_n_i,
  input  wire logic              ce_i,
  input  wire logic              req_valid_i,
  input  wire tsc_pkg::tsc_req_s req_i,
  output logic                   req_ready_o,
  output logic                   done_o,
  output tsc_pkg::tsc_trap_e     trap_o,
  output tsc_pkg::tsc_mem_s      mem_o,
  input  wire logic              mem_ack_i,
  input  wire logic [39:0]       mem_rdata_i,
  input  wire logic              mem_transport_i,
  input  wire logic [31:0]       s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [31:0]       s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);
  import tsc_pkg::*;

  typedef struct packed {
    tsc_state_e  state;
    logic        req_ready;
    logic        done;
    tsc_trap_e   trap;
    tsc_mem_s    mem;
    logic        is_arr;
    logic [1:0]  list_code;
    logic [31:0] arr_desc;
    logic [31:0] arr_len;
    logic [31:0] mem_ofs;
    logic [2:0]  pack_sh;
    logic        aw_held;
    logic        w_held;
    logic [7:0]  awaddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } tsc_st_s;

  tsc_st_s st;
  tsc_st_s next_st;

  // byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                       input logic [31:0] new_v,
                                       input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction

  // classify the word found at the target before it is overwritten
  function automatic tsc_trap_e word_trap(input logic [5:0] tag,
                                          input logic       transport);
    tsc_trap_e t;
    t = TSC_TRAP_NONE;
    if (tag == `TSC_TAG_HDR_P || tag == `TSC_TAG_HDR_I ||
        tag == `TSC_TAG_GC_FWD) begin
      t = TSC_TRAP_MEM_ERROR;
    end else if (tag == `TSC_TAG_MON_FWD) begin
      t = TSC_TRAP_MONITOR;
    end else if (tag == `TSC_TAG_EVCP || tag == `TSC_TAG_ONEQ_FWD ||
                 tag == `TSC_TAG_HDR_FWD || tag == `TSC_TAG_ELEM_FWD) begin
      t = TSC_TRAP_INDIRECT;
    end else if (tag == `TSC_TAG_BOUND) begin
      t = TSC_TRAP_BOUND;
    end else if (tag == `TSC_TAG_LOGIC) begin
      t = TSC_TRAP_LOGIC_VAR;
    end
    // transport only overrides the deferrable word traps
    if (transport && t != TSC_TRAP_NONE && t != TSC_TRAP_MEM_ERROR) begin
      t = TSC_TRAP_TRANSPORT;
    end
    return t;
  endfunction

  // all next-state logic: store sequencer and register slave
  always_comb begin
    logic [31:0] ofs;
    logic [31:0] base;
    logic [31:0] addr;
    logic [1:0]  et;
    logic        is_arr;
    logic        accept;
    logic        elem_bad;
    tsc_trap_e   pre;
    tsc_trap_e   wt;
    next_st  = st;
    ofs      = '0;
    base     = '0;
    addr     = '0;
    elem_bad = 1'b0;
    et       = st.arr_desc[`TSC_AHR_ET_HI:`TSC_AHR_ET_LO];
    is_arr   = (req_i.opcode == `TSC_OP_ARRAY);
    accept   = req_valid_i && st.req_ready &&
               (is_arr || req_i.opcode == `TSC_OP_RPLACD);
    pre      = TSC_TRAP_NONE;
    wt       = word_trap(mem_rdata_i[`TSC_TAG_HI:`TSC_TAG_LO],
                         mem_transport_i);
    unique case (req_i.fmt)
      `TSC_FMT_RR:  ofs = st.mem_ofs;
      `TSC_FMT_RIS: ofs = {{20{req_i.imm12[11]}}, req_i.imm12};
      default:      ofs = req_i.imm38[31:0];
    endcase
    base = req_i.src1[`TSC_DATA_HI:0] + ofs;
    addr = base;
    // element store skips the descriptor word
    if (is_arr) begin
      addr = base + 32'h0000_0001;
    // locative source1 in the RIS format is itself the address
    end else if (req_i.fmt == `TSC_FMT_RIS &&
                 req_i.src1[`TSC_TAG_HI:`TSC_TAG_LO] == `TSC_TAG_LOCATIVE) begin
      addr = req_i.src1[`TSC_DATA_HI:0];
    end
    elem_bad = (et == `TSC_ET_BOOL) ||
               (et == `TSC_ET_CHAR &&
                (req_i.src2[`TSC_TAG_HI:`TSC_TAG_LO] != `TSC_TAG_CHAR ||
                 req_i.src2[`TSC_CHAR_OVER_BIT])) ||
               (et == `TSC_ET_FIXNUM &&
                req_i.src2[`TSC_TAG_HI:`TSC_TAG_LO] != `TSC_TAG_FIXNUM);
    if (req_i.src1[`TSC_TAG_HI:`TSC_TAG_LO] != req_i.typ) begin
      pre = TSC_TRAP_SRC_TYPE;
    end else if (!is_arr && st.list_code != `TSC_CDR_NORMAL) begin
      pre = TSC_TRAP_LIST_CODE;
    end else if (is_arr && elem_bad) begin
      pre = TSC_TRAP_ELEMENT;
    end else if (is_arr && st.arr_desc[`TSC_AHR_LONG] &&
                 !st.arr_desc[`TSC_AHR_INHIBIT]) begin
      pre = TSC_TRAP_LONG_PFX;
    end else if (is_arr && ofs >= st.arr_len) begin
      pre = TSC_TRAP_RANGE;
    end else if (is_arr &&
                 (st.arr_desc[`TSC_AHR_PK_HI:`TSC_AHR_PK_LO] != 3'h0 ||
                  et == `TSC_ET_CHAR)) begin
      pre = TSC_TRAP_PACKED;
    end

    // store sequencer: pre-checks, read old word, then write
    unique case (st.state)
      TSC_ST_IDLE: begin
        if (accept) begin
          next_st.is_arr = is_arr;
          next_st.mem.addr = addr;
          next_st.mem.wdata = req_i.src2;
          // packing encoding captured on every element store
          if (is_arr) begin
            next_st.pack_sh = st.arr_desc[`TSC_AHR_PK_HI:`TSC_AHR_PK_LO];
          end
          if (pre != TSC_TRAP_NONE) begin
            next_st.trap = pre;
            next_st.done = 1'b1;
            next_st.state = TSC_ST_DONE;
          end else begin
            next_st.mem.req = 1'b1;
            next_st.mem.we = 1'b0;
            next_st.state = TSC_ST_RD;
          end
        end
      end
      TSC_ST_RD: begin
        if (mem_ack_i) begin
          // word traps only reached once array checks pass
          if (wt != TSC_TRAP_NONE) begin
            next_st.mem.req = 1'b0;
            next_st.trap = wt;
            next_st.done = 1'b1;
            next_st.state = TSC_ST_DONE;
          // write issued only when nothing trapped
          end else begin
            next_st.mem.we = 1'b1;
            next_st.state = TSC_ST_WR;
          end
        end
      end
      TSC_ST_WR: begin
        if (mem_ack_i) begin
          next_st.mem.req = 1'b0;
          next_st.mem.we = 1'b0;
          next_st.trap = TSC_TRAP_NONE;
          next_st.done = 1'b1;
          next_st.state = TSC_ST_DONE;
        end
      end
      TSC_ST_DONE: begin
        next_st.done = 1'b0;
        next_st.state = TSC_ST_IDLE;
      end
    endcase
    next_st.req_ready = (next_st.state == TSC_ST_IDLE);

    // bus write: address and data taken in either order
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    if (s_axi_awvalid && st.awready) begin
      next_st.aw_held = 1'b1;
      next_st.awaddr = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && st.wready) begin
      next_st.w_held = 1'b1;
      next_st.wdata = s_axi_wdata;
      next_st.wstrb = s_axi_wstrb;
    end
    if (next_st.aw_held && next_st.w_held && !next_st.bvalid) begin
      next_st.aw_held = 1'b0;
      next_st.w_held = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = `TSC_RESP_OKAY;
      unique case (next_st.awaddr)
        // only the low byte lane reaches the two-bit field
        `TSC_REG_LIST_CODE: next_st.list_code =
          next_st.wstrb[0] ? next_st.wdata[1:0] : st.list_code;
        `TSC_REG_ARR_DESC: next_st.arr_desc =
          merge(st.arr_desc, next_st.wdata, next_st.wstrb);
        `TSC_REG_ARR_LEN: next_st.arr_len =
          merge(st.arr_len, next_st.wdata, next_st.wstrb);
        `TSC_REG_MEM_OFS: next_st.mem_ofs =
          merge(st.mem_ofs, next_st.wdata, next_st.wstrb);
        `TSC_REG_PACK_SH, `TSC_REG_STATUS: ; // read-only, ignored
        default: next_st.bresp = `TSC_RESP_SLVERR;
      endcase
    end
    // ready only while a slot is free, so no beat is dropped
    next_st.awready = !next_st.aw_held && !next_st.bvalid;
    next_st.wready = !next_st.w_held && !next_st.bvalid;

    // bus read: one outstanding, answer one cycle after arrival
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st.arready) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = `TSC_RESP_OKAY;
      unique case (s_axi_araddr[7:0])
        `TSC_REG_LIST_CODE: next_st.rdata = {30'h0, st.list_code};
        `TSC_REG_ARR_DESC:  next_st.rdata = st.arr_desc;
        `TSC_REG_ARR_LEN:   next_st.rdata = st.arr_len;
        `TSC_REG_MEM_OFS:   next_st.rdata = st.mem_ofs;
        `TSC_REG_PACK_SH:   next_st.rdata = {29'h0, st.pack_sh};
        `TSC_REG_STATUS:    next_st.rdata = {23'h0, st.state, 1'b0, st.trap};
        default: begin
          next_st.rdata = '0;
          next_st.rresp = `TSC_RESP_SLVERR;
        end
      endcase
    end
    next_st.arready = !next_st.rvalid;
  end

  // state register; ce low freezes every field
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= '0;
      st.state <= TSC_ST_IDLE;
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  // outputs taken straight from the state register
  assign req_ready_o   = st.req_ready;
  assign done_o        = st.done;
  assign trap_o        = st.trap;
  assign mem_o         = st.mem;
  assign s_axi_awready = st.awready;
  assign s_axi_wready  = st.wready;
  assign s_axi_bvalid  = st.bvalid;
  assign s_axi_bresp   = st.bresp;
  assign s_axi_arready = st.arready;
  assign s_axi_rvalid  = st.rvalid;
  assign s_axi_rdata   = st.rdata;
  assign s_axi_rresp   = st.rresp;

  // checks; the request and memory ones gated by ce_i, the write and bus ones sampled on every cycle
  logic acc_c;
  logic tag_ok;
  logic wt_ok;
  assign acc_c  = ce_i && req_valid_i && st.req_ready;
  assign tag_ok = req_i.src1[`TSC_TAG_HI:`TSC_TAG_LO] == req_i.typ;
  // trap_o keeps the last trap, so the write check looks at the old word
  assign wt_ok  = word_trap(mem_rdata_i[`TSC_TAG_HI:`TSC_TAG_LO],
                            mem_transport_i) == TSC_TRAP_NONE;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  a_src_type_first: assert property (
    acc_c && !tag_ok && (req_i.opcode == `TSC_OP_ARRAY ||
    req_i.opcode == `TSC_OP_RPLACD) |=> done_o &&
    trap_o == TSC_TRAP_SRC_TYPE) else $error("source type trap lost");
  a_list_code_trap: assert property (
    acc_c && tag_ok && req_i.opcode == `TSC_OP_RPLACD &&
    st.list_code != `TSC_CDR_NORMAL |=> trap_o == TSC_TRAP_LIST_CODE
    && !mem_o.req) else $error("list code trap missing");
  a_long_prefix: assert property (
    acc_c && tag_ok && req_i.opcode == `TSC_OP_ARRAY && !elem_chk() &&
    st.arr_desc[`TSC_AHR_LONG] && !st.arr_desc[`TSC_AHR_INHIBIT]
    |=> trap_o == TSC_TRAP_LONG_PFX) else $error("long prefix missed");
  a_array_addr: assert property (
    acc_c && tag_ok && req_i.opcode == `TSC_OP_ARRAY &&
    req_i.fmt == `TSC_FMT_RR |=> mem_o.req == 1'b0 ||
    mem_o.addr == $past(req_i.src1[31:0]) + $past(st.mem_ofs) + 32'h1)
    else $error("element address wrong");
  a_mem_err_trap: assert property (
    ce_i && st.state == TSC_ST_RD && mem_ack_i &&
    mem_rdata_i[`TSC_TAG_HI:`TSC_TAG_LO] == `TSC_TAG_GC_FWD
    |=> done_o && trap_o == TSC_TRAP_MEM_ERROR && !mem_o.req)
    else $error("memory error trap missing");
  a_transport_wins: assert property (
    ce_i && st.state == TSC_ST_RD && mem_ack_i && mem_transport_i &&
    mem_rdata_i[`TSC_TAG_HI:`TSC_TAG_LO] == `TSC_TAG_MON_FWD
    |=> trap_o == TSC_TRAP_TRANSPORT) else $error("transport lost");
  a_write_clean: assert property (
    $rose(mem_o.we) |-> $past(st.state) == TSC_ST_RD && $past(mem_ack_i)
    && $past(wt_ok)) else $error("store after trap");
  a_pack_load: assert property (
    acc_c && req_i.opcode == `TSC_OP_ARRAY |=> st.pack_sh ==
    $past(st.arr_desc[`TSC_AHR_PK_HI:`TSC_AHR_PK_LO]))
    else $error("packing shift not loaded");
  a_bvalid_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");

  function automatic logic elem_chk();
    return st.arr_desc[`TSC_AHR_ET_HI:`TSC_AHR_ET_LO] == `TSC_ET_BOOL ||
           st.arr_desc[`TSC_AHR_ET_HI:`TSC_AHR_ET_LO] == `TSC_ET_CHAR ||
           req_i.src2[`TSC_TAG_HI:`TSC_TAG_LO] != `TSC_TAG_FIXNUM;
  endfunction

  c_clean_store: cover property (mem_o.req && mem_o.we ##[1:20] done_o);
  c_transport: cover property (done_o && trap_o == TSC_TRAP_TRANSPORT);
  c_range_trap: cover property (done_o && trap_o == TSC_TRAP_RANGE);
endmodule
`default_nettype wire

// ### tb/tsc_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// memory side: one access at a time, ack after a settable delay
module tsc_mem_model (
  input  wire logic              clock_i,
  input  wire logic              rst_n_i,
  input  wire tsc_pkg::tsc_mem_s mem_i,
  output logic                   ack_o,
  output logic [39:0]            rdata_o,
  output logic                   transport_o
);
  import tsc_pkg::*;
  logic [39:0] old_word  = 40'h0000000000; // set by the bench per case
  logic        trans     = 1'b0;
  int          delay     = 0;
  int          cnt;
  int          acc_cnt   = 0;
  int          wr_cnt    = 0;
  logic [31:0] last_addr = 32'h00000000;
  logic [39:0] wr_data   = 40'h0000000000;
  // outside an ack the lines show the inverse, never a stale valid word
  assign rdata_o     = ack_o ? old_word : ~old_word;
  assign transport_o = ack_o ? trans : ~trans;
  // wait out the delay, then pulse ack for exactly one cycle
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_o <= 1'b0;
      cnt   <= 0;
    end else if (ack_o || !mem_i.req) begin
      ack_o <= 1'b0; // request must be seen again after each ack
      cnt   <= 0;
    end else if (cnt >= delay) begin
      ack_o     <= 1'b1;
      acc_cnt   <= acc_cnt + 1;
      wr_cnt    <= wr_cnt + int'(mem_i.we);
      last_addr <= mem_i.addr;
      wr_data   <= mem_i.we ? mem_i.wdata : wr_data;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule
`default_nettype wire

// ### tb/tagged_store_trap_check_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "tsc_defines.svh"
module tagged_store_trap_check_bench;
  import tsc_pkg::*;
  localparam logic [5:0] FX = `TSC_TAG_FIXNUM;
  localparam logic [5:0] CH = `TSC_TAG_CHAR;
  localparam logic [1:0] EF = `TSC_ET_FIXNUM;
  localparam logic [1:0] EC = `TSC_ET_CHAR;
  logic        clock_i;
  logic        rst_n_i;
  logic        ce;
  logic        req_valid;
  tsc_req_s    req;
  logic        ready;
  logic        done;
  tsc_trap_e   trap;
  tsc_mem_s    mem;
  logic        ack;
  logic [39:0] rdata;
  logic        trans;
  logic [31:0] awaddr, wdata, araddr, rdat;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  int          bad_count = 0;
  int          n_checks  = 0;
  tsc_store_check tsc_store_check_inst (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(ce),
    .req_valid_i(req_valid), .req_i(req), .req_ready_o(ready),
    .done_o(done), .trap_o(trap), .mem_o(mem), .mem_ack_i(ack),
    .mem_rdata_i(rdata), .mem_transport_i(trans),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdat), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready)
  );
  tsc_mem_model tsc_mem_model_inst (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .mem_i(mem), .ack_o(ack),
    .rdata_o(rdata), .transport_o(trans)
  );
  // 125 MHz clock
  initial begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end
  task automatic results();
    $display("checks %0d, mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // one counted comparison; any ok other than 1 counts as a mismatch
  task automatic chk(input logic ok, input string m);
    n_checks++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  function automatic logic [39:0] w(input logic [5:0] t,
                                    input logic [31:0] v);
    w = {`TSC_CDR_NORMAL, t, v};
  endfunction
  // f is {long prefix, inhibit}
  function automatic logic [31:0] dsc(input logic [1:0] et,
                                      input logic [2:0] pk,
                                      input logic [1:0] f);
    dsc = {et, pk, 3'h0, f[1], 10'h000, f[0], 12'h000};
  endfunction
  function automatic tsc_req_s mk(input logic [5:0] op,
      input logic [2:0] f, input logic [5:0] ty, input logic [39:0] s1,
      input logic [39:0] s2, input logic [11:0] i12,
      input logic [37:0] i38);
    mk = '{op, f, ty, s1, s2, i12, i38};
  endfunction
  // old word tag decides the trap
  function automatic tsc_trap_e wexp(input logic [5:0] t, input logic tr);
    case (t)
      `TSC_TAG_HDR_P, `TSC_TAG_HDR_I, `TSC_TAG_GC_FWD:
        wexp = TSC_TRAP_MEM_ERROR; // error trap ignores transport
      `TSC_TAG_MON_FWD: wexp = tr ? TSC_TRAP_TRANSPORT : TSC_TRAP_MONITOR;
      `TSC_TAG_BOUND: wexp = tr ? TSC_TRAP_TRANSPORT : TSC_TRAP_BOUND;
      `TSC_TAG_LOGIC: wexp = tr ? TSC_TRAP_TRANSPORT : TSC_TRAP_LOGIC_VAR;
      FX, CH: wexp = TSC_TRAP_NONE;
      default: wexp = tr ? TSC_TRAP_TRANSPORT : TSC_TRAP_INDIRECT;
    endcase
  endfunction
  // register write, address and data offered together
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [3:0] s, input logic [1:0] r);
    int k;
    awaddr  <= {24'h000000, a};
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (k = 0; k < 100; k++) begin
      @(posedge clock_i);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    if (k == 100) chk(1'b0, "no write response");
    if (k == 100) results();
    chk(bresp === r, "write response code");
    bready <= 1'b0;
    @(posedge clock_i); // keeps the next raise out of this time step
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] r);
    int k;
    araddr  <= {24'h000000, a};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (k = 0; k < 100; k++) begin
      @(posedge clock_i);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    if (k == 100) chk(1'b0, "no read response");
    if (k == 100) results();
    chk(rdat === d && rresp === r, "read data or code");
    rready <= 1'b0;
    @(posedge clock_i);
  endtask
  task automatic setarr(input logic [31:0] dw, input logic [31:0] len);
    axi_wr(`TSC_REG_ARR_DESC, dw, 4'hF, `TSC_RESP_OKAY);
    axi_wr(`TSC_REG_ARR_LEN, len, 4'hF, `TSC_RESP_OKAY);
  endtask
  // issue one store, wait for done, judge trap and memory traffic
  task automatic run(input tsc_req_s q, input tsc_trap_e et,
                     input logic rd, input logic wr, input logic [31:0] ea);
    int k;
    int a0;
    int w0;
    a0 = tsc_mem_model_inst.acc_cnt;
    w0 = tsc_mem_model_inst.wr_cnt;
    req       <= q;
    req_valid <= 1'b1;
    k = 0;
    do begin
      @(posedge clock_i);
      k++;
    end while (ready !== 1'b1 && k < 100);
    req_valid <= 1'b0;
    do begin
      @(posedge clock_i);
      k++;
    end while (done !== 1'b1 && k < 300);
    if (k >= 300) chk(1'b0, "store never completed");
    if (k >= 300) results();
    chk(trap === et, "trap code");
    a0 = tsc_mem_model_inst.acc_cnt - a0;
    w0 = tsc_mem_model_inst.wr_cnt - w0;
    chk(a0 == int'(rd) + int'(wr) && w0 == int'(wr), "accesses");
    if (rd) chk(tsc_mem_model_inst.last_addr === ea, "target address");
    if (wr) chk(tsc_mem_model_inst.wr_data === q.src2, "stored word");
  endtask
  // strobes, readback and an unmapped address
  task automatic t_bus();
    axi_wr(`TSC_REG_ARR_DESC, 32'hFFFFFFFF, 4'hF, `TSC_RESP_OKAY);
    axi_wr(`TSC_REG_ARR_DESC, 32'h00000000, 4'h1, `TSC_RESP_OKAY);
    axi_rd(`TSC_REG_ARR_DESC, 32'hFFFFFF00, `TSC_RESP_OKAY);
    axi_wr(8'h40, 32'h00000001, 4'hF, `TSC_RESP_SLVERR);
    axi_rd(8'h40, 32'h00000000, `TSC_RESP_SLVERR);
  endtask
  task automatic tail(input logic [2:0] f, input logic [39:0] s1,
                      input logic [11:0] i, input logic [37:0] i38,
                      input logic [31:0] ea);
    run(mk(`TSC_OP_RPLACD, f, s1[37:32], s1, w(CH, 32'h00000041), i, i38),
        TSC_TRAP_NONE, 1'b1, 1'b1, ea);
  endtask
  // address forms, prompt then slow memory
  task automatic t_tail();
    logic [39:0] s1;
    s1 = w(FX, 32'h00000100);
    tsc_mem_model_inst.old_word = w(FX, 32'h00000005);
    tail(`TSC_FMT_RIS, s1, 12'h010, 38'h0, 32'h00000110);
    tsc_mem_model_inst.delay = 3;
    tail(`TSC_FMT_RIS, s1, 12'hFFF, 38'h0, 32'h000000FF);
    tail(`TSC_FMT_RIL, s1, 12'h000, 38'h2000, 32'h00002100);
    s1 = w(`TSC_TAG_LOCATIVE, 32'h00000300);
    tail(`TSC_FMT_RIS, s1, 12'h010, 38'h0, 32'h00000300);
    tsc_mem_model_inst.delay = 0;
  endtask
  // list code other than normal, and a wrong source1 type
  task automatic t_pre();
    tsc_req_s q;
    q = mk(`TSC_OP_RPLACD, `TSC_FMT_RIS, FX, w(FX, 32'h00000100),
           w(FX, 32'h00000001), 12'h000, 38'h0);
    for (int v = 1; v < 4; v++) begin
      axi_wr(`TSC_REG_LIST_CODE, v, 4'hF, `TSC_RESP_OKAY);
      run(q, TSC_TRAP_LIST_CODE, 1'b0, 1'b0, 32'h0);
    end
    axi_wr(`TSC_REG_LIST_CODE, 32'h00000000, 4'hF, `TSC_RESP_OKAY);
    setarr(dsc(`TSC_ET_BOOL, 3'h7, 2'h2), 32'h00000000);
    q.src1 = w(CH, 32'h00000100);
    run(q, TSC_TRAP_SRC_TYPE, 1'b0, 1'b0, 32'h0);
    q.opcode = `TSC_OP_ARRAY;
    run(q, TSC_TRAP_SRC_TYPE, 1'b0, 1'b0, 32'h0);
  endtask
  // every trapping old word tag plus fixnum and character, with and without transport, both stores
  task automatic t_words();
    logic [5:0]  tg [12] = '{`TSC_TAG_HDR_P, `TSC_TAG_HDR_I,
      `TSC_TAG_GC_FWD, `TSC_TAG_MON_FWD, `TSC_TAG_EVCP, `TSC_TAG_ONEQ_FWD,
      `TSC_TAG_HDR_FWD, `TSC_TAG_ELEM_FWD, `TSC_TAG_BOUND, `TSC_TAG_LOGIC,
      FX, CH};
    tsc_trap_e   e;
    tsc_req_s    q;
    setarr(dsc(EF, 3'h0, 2'h0), 32'h00000100);
    for (int i = 0; i < 12; i++) begin
      for (int t = 0; t < 4; t++) begin
        tsc_mem_model_inst.old_word = w(tg[i], 32'h00000000);
        tsc_mem_model_inst.trans = t[0];
        e = wexp(tg[i], t[0]);
        q = mk(t[1] ? `TSC_OP_ARRAY : `TSC_OP_RPLACD, `TSC_FMT_RIS, FX,
               w(FX, 32'h00000200), w(FX, 32'h00000009), 12'h004, 38'h0);
        run(q, e, 1'b1, e == TSC_TRAP_NONE, {30'h81, 1'b0, t[1]});
      end
    end
    tsc_mem_model_inst.old_word = w(FX, 32'h00000000);
    tsc_mem_model_inst.trans = 1'b0;
  endtask
  task automatic arr(input logic [31:0] dw, input logic [31:0] len,
                     input logic [39:0] s2, input logic [11:0] i,
                     input tsc_trap_e e);
    setarr(dw, len);
    run(mk(`TSC_OP_ARRAY, `TSC_FMT_RIS, FX, w(FX, 32'h00001000), s2, i,
           38'h0), e, e == TSC_TRAP_NONE, e == TSC_TRAP_NONE,
        32'h00001001 + {20'h00000, i});
  endtask
  // array trap conditions, their order, and the offset forms
  task automatic t_array();
    logic [39:0] fx;
    logic [39:0] ch;
    fx = w(FX, 32'h00000007);
    ch = w(CH, 32'h00000041);
    arr(dsc(EF, 3'h0, 2'h0), 32'h10, fx, 12'h00F, TSC_TRAP_NONE);
    arr(dsc(EF, 3'h0, 2'h0), 32'h10, fx, 12'h010, TSC_TRAP_RANGE);
    arr(dsc(`TSC_ET_BOOL, 3'h5, 2'h2), 32'h0, fx, 12'h1,
        TSC_TRAP_ELEMENT);
    arr(dsc(EF, 3'h5, 2'h2), 32'h0, fx, 12'h1, TSC_TRAP_LONG_PFX);
    arr(dsc(EF, 3'h5, 2'h3), 32'h0, fx, 12'h1, TSC_TRAP_RANGE);
    arr(dsc(EF, 3'h5, 2'h0), 32'h10, fx, 12'h1, TSC_TRAP_PACKED);
    axi_rd(`TSC_REG_PACK_SH, 32'h00000005, `TSC_RESP_OKAY);
    arr(dsc(EC, 3'h0, 2'h0), 32'h10, ch, 12'h1, TSC_TRAP_PACKED);
    arr(dsc(EC, 3'h0, 2'h0), 32'h10, w(CH, 32'h00100041), 12'h1,
        TSC_TRAP_ELEMENT);
    arr(dsc(EC, 3'h0, 2'h0), 32'h10, fx, 12'h1, TSC_TRAP_ELEMENT);
    arr(dsc(EF, 3'h0, 2'h0), 32'h10, ch, 12'h1, TSC_TRAP_ELEMENT);
    arr(dsc(EF, 3'h0, 2'h3), 32'h100, fx, 12'h1, TSC_TRAP_NONE);
    axi_wr(`TSC_REG_MEM_OFS, 32'h00000020, 4'hF, `TSC_RESP_OKAY);
    run(mk(`TSC_OP_ARRAY, `TSC_FMT_RR, FX, w(FX, 32'h00001000), fx, 12'h0,
           38'h0), TSC_TRAP_NONE, 1'b1, 1'b1, 32'h00001021);
    run(mk(`TSC_OP_ARRAY, `TSC_FMT_RIL, FX, w(FX, 32'h00001000), fx, 12'h0,
           38'h40), TSC_TRAP_NONE, 1'b1, 1'b1, 32'h00001041);
  endtask
  // reset for two cycles, then each scenario in turn
  initial begin
    rst_n_i   = 1'b0;
    ce        = 1'b0;
    req_valid = 1'b0;
    req       = '0;
    {awaddr, wdata, araddr, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    repeat (2) @(posedge clock_i);
    rst_n_i <= 1'b1;
    // enable held low: the readies must not leave their reset value
    repeat (3) @(posedge clock_i);
    chk(ready === 1'b0 && awready === 1'b0, "state moved while disabled");
    ce <= 1'b1;
    repeat (2) @(posedge clock_i);
    t_bus();
    t_tail();
    t_pre();
    t_words();
    t_array();
    results();
  end
endmodule
`default_nettype wire
